// *** rtl/scp_pkg.sv ***
// constants and types for the serial control port
// assumes a single system clock; all pins are asynchronous to it
package scp_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_PORT_CFG = 16'h0000;
    localparam logic [15:0] ADDR_READ_SEL = 16'h0004;
    localparam logic [15:0] ADDR_UPDATE   = 16'h0232;
    localparam logic [15:0] ARR_BASE      = 16'h0010;
    localparam int          ARR_N         = 8;
    localparam logic [15:0] ARR_LAST      = 16'h0017;

    localparam int CFG_DIR_LO   = 0;
    localparam int CFG_LSB_LO   = 1;
    localparam int CFG_DIR_HI   = 7;
    localparam int READ_SEL_BIT = 0;
    localparam int UPDATE_BIT   = 0;

    // long instruction mode mirrored in bits 4 and 3, msb first, bidirectional
    localparam logic [7:0] CFG_RESET      = 8'h18;
    localparam logic       READ_SEL_RESET = 1'b0;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;

    // ------------------------------------------------------------
    // serial framing
    // ------------------------------------------------------------
    localparam logic [4:0]  INSTR_LAST = 5'h0f;
    localparam logic [4:0]  BYTE_LAST  = 5'h07;
    localparam logic [3:0]  I2C_ACK_CNT = 4'h8;
    localparam logic [1:0]  LEN_STREAM = 2'h3;
    localparam logic [12:0] SPI_STEP   = 13'h0001;
    localparam logic [15:0] I2C_STEP   = 16'h0001;

    typedef struct packed {
        logic        rd;
        logic [1:0]  length_code_bits;
        logic [12:0] start_reg_address;
    } scp_instr_t;

    typedef struct packed {
        logic        en;
        logic [15:0] addr;
        logic [7:0]  data;
    } scp_wr_t;

    typedef enum logic [1:0] {
        SP_INSTR = 2'b00,
        SP_DATA  = 2'b01,
        SP_DONE  = 2'b10
    } scp_spi_state_t;

    typedef enum logic [2:0] {
        I_IDLE  = 3'b000,
        I_ADDR  = 3'b001,
        I_RX    = 3'b010,
        I_ACK   = 3'b011,
        I_TX    = 3'b100,
        I_TXACK = 3'b101
    } scp_i2c_state_t;

endpackage : scp_pkg

// *** rtl/scp_serial_control_port.sv ***
// serial control port: spi and i2c slave onto a shadow/active register file
// assumes every serial pin is asynchronous to clock and is oversampled by it
`timescale 1ns/1ps
`default_nettype none

// How it works
// - i2c write of only two address bytes then stop loads the pointer.
// - i2c write stores each data byte from the given address, acking every byte.
// - i2c read returns bytes from the pointer until host sends no-ack.
// - combined read sets address, repeated start, then returns data from it.
// - spi bits are captured on sclk rise, read bits change on sclk fall.
// - after reset one bidirectional data pin is used, direction bit zero.
// - chip select high keeps both data outputs released.
// - only the sixteen-bit instruction word is accepted.
// - short transfers may pause on byte boundaries; device waits for the rest.
// - a short abort pulse of one to seven clocks resets the port.
// - chip select rising off a byte boundary aborts and resets the port.
// - streaming takes any number of bytes, stepping the address, until cs rises.
// - first sixteen rising edges carry direction, length and start address.
// - two length bits pick one, two, three bytes or streaming.
// - streaming steps through every address, reserved ones included.
// - array writes land in a shadow; the update bit copies all into active at once.
// - reads shift out n bytes in n times eight clocks, or stream.
// - both direction bits set move read data to the separate output pin.
// - a configuration bit picks shadow or active contents for readback.
// - bidirectional mode turns the data pin around for the read phase.
// - after a pause the transfer resumes exactly where it stopped.
// - instruction holds read flag, two length bits, thirteen address bits.
// - length codes 00,01,10,11 mean one, two, three bytes, streaming.
// - address decrements per byte msb first, increments lsb first.
module scp_serial_control_port (
    input  wire logic                         clock,
    input  wire logic                         resetn,
    input  wire logic                         spi_mode,
    input  wire logic [6:0]                   i2c_slave_addr,
    input  wire logic                         sclk,
    input  wire logic                         csn,
    input  wire logic                         sdio_in,
    output var  logic                         sdio_out,
    output var  logic                         sdio_oe_n,
    output var  logic                         serial_out_pin,
    output var  logic                         serial_out_oe_n,
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    output var  logic                         sda_out,
    output var  logic                         sda_oe_n,
    output var  logic [scp_pkg::ARR_N*8-1:0]  active_regs,
    output var  logic                         update_pulse
);
    import scp_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] s1_r, s2_r, s3_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s1_r <= 5'h1f;
            s2_r <= 5'h1f;
            s3_r <= 5'h1f;
        end else begin
            s1_r <= {csn, sclk, sdio_in, scl_in, sda_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    logic csn_s, sclk_rise, sclk_fall, sdio_s, cs_rise;
    logic scl_rise, scl_fall, sda_s, i2c_start, i2c_stop;
    assign csn_s     = s2_r[4];
    assign cs_rise   = s2_r[4] & ~s3_r[4];
    assign sclk_rise = s2_r[3] & ~s3_r[3];
    assign sclk_fall = ~s2_r[3] & s3_r[3];
    assign sdio_s    = s2_r[2];
    assign scl_rise  = s2_r[1] & ~s3_r[1];
    assign scl_fall  = ~s2_r[1] & s3_r[1];
    assign sda_s     = s2_r[0];
    assign i2c_start = s2_r[1] & s3_r[1] & s3_r[0] & ~s2_r[0];
    assign i2c_stop  = s2_r[1] & s3_r[1] & ~s3_r[0] & s2_r[0];

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] cfg_r, cfg_nxt;
    logic       rsel_r, rsel_nxt;
    logic [7:0] shadow_r [ARR_N];
    logic [7:0] shadow_nxt [ARR_N];
    logic [7:0] active_r [ARR_N];
    logic [7:0] active_nxt [ARR_N];
    logic       upd_r, upd_nxt;
    scp_wr_t    spi_wr, i2c_wr, wr;
    logic       lsb_first, unidir;

    assign lsb_first = cfg_r[CFG_LSB_LO];
    assign unidir    = cfg_r[CFG_DIR_HI] & cfg_r[CFG_DIR_LO];

    function automatic logic [7:0] rd_byte(input logic [15:0] a);
        logic [15:0] off;
        off = a - ARR_BASE;
        if (a == ADDR_PORT_CFG)
            return cfg_r;
        else if (a == ADDR_READ_SEL)
            return {7'h00, rsel_r};
        else if (a >= ARR_BASE && a <= ARR_LAST)
            return rsel_r ? active_r[off[2:0]] : shadow_r[off[2:0]];
        else
            return BYTE_ZERO; // reserved, unmapped and self-clearing update read as zero
    endfunction

    always_comb begin
        logic [15:0] off;
        wr       = spi_mode ? spi_wr : i2c_wr;
        off      = wr.addr - ARR_BASE;
        cfg_nxt  = cfg_r;
        rsel_nxt = rsel_r;
        upd_nxt  = 1'b0;
        for (int i = 0; i < ARR_N; i++) begin
            shadow_nxt[i] = shadow_r[i];
            active_nxt[i] = active_r[i];
        end
        if (wr.en) begin
            // port config acts at once; it only steers the serial port
            if (wr.addr == ADDR_PORT_CFG)
                cfg_nxt = wr.data;
            else if (wr.addr == ADDR_READ_SEL)
                rsel_nxt = wr.data[READ_SEL_BIT];
            else if (wr.addr == ADDR_UPDATE && wr.data[UPDATE_BIT]) begin
                upd_nxt = 1'b1;
                for (int i = 0; i < ARR_N; i++)
                    active_nxt[i] = shadow_r[i];
            end else if (wr.addr >= ARR_BASE && wr.addr <= ARR_LAST)
                shadow_nxt[off[2:0]] = wr.data;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cfg_r  <= CFG_RESET;
            rsel_r <= READ_SEL_RESET;
            upd_r  <= 1'b0;
            for (int i = 0; i < ARR_N; i++) begin
                shadow_r[i] <= BYTE_ZERO;
                active_r[i] <= BYTE_ZERO;
            end
        end else begin
            cfg_r  <= cfg_nxt;
            rsel_r <= rsel_nxt;
            upd_r  <= upd_nxt;
            for (int i = 0; i < ARR_N; i++) begin
                shadow_r[i] <= shadow_nxt[i];
                active_r[i] <= active_nxt[i];
            end
        end
    end

    for (genvar g = 0; g < ARR_N; g++) begin : g_out
        assign active_regs[g*8 +: 8] = active_r[g];
    end
    assign update_pulse = upd_r;

    // ------------------------------------------------------------
    // spi engine
    // ------------------------------------------------------------
    scp_spi_state_t sp_r, sp_nxt;
    logic [4:0]  bit_r, bit_nxt;
    logic [15:0] ish_r, ish_nxt;
    logic [7:0]  rx_r, rx_nxt, tx_r, tx_nxt;
    logic [12:0] addr_r, addr_nxt;
    logic        rd_r, rd_nxt, drv_r, drv_nxt, obit_r, obit_nxt;
    logic [1:0]  len_r, len_nxt, bcnt_r, bcnt_nxt;

    always_comb begin
        scp_instr_t  w;
        logic [7:0]  rxb;
        logic [12:0] astep;
        w        = lsb_first ? {sdio_s, ish_r[15:1]} : {ish_r[14:0], sdio_s};
        rxb      = lsb_first ? {sdio_s, rx_r[7:1]} : {rx_r[6:0], sdio_s};
        astep    = lsb_first ? addr_r + SPI_STEP : addr_r - SPI_STEP;
        sp_nxt   = sp_r;
        bit_nxt  = bit_r;
        ish_nxt  = ish_r;
        rx_nxt   = rx_r;
        tx_nxt   = tx_r;
        addr_nxt = addr_r;
        rd_nxt   = rd_r;
        drv_nxt  = drv_r;
        obit_nxt = obit_r;
        len_nxt  = len_r;
        bcnt_nxt = bcnt_r;
        spi_wr   = '0;
        if (!spi_mode) begin
            sp_nxt  = SP_INSTR;
            bit_nxt = '0;
            drv_nxt = 1'b0;
        end else if (cs_rise) begin
            // a pause is legal only on a byte boundary, and in the data phase only of a counted transfer
            if (bit_r[2:0] != 3'h0 || sp_r == SP_DONE
                || (sp_r == SP_DATA && len_r == LEN_STREAM)) begin
                sp_nxt   = SP_INSTR;
                bit_nxt  = '0;
                bcnt_nxt = '0;
                drv_nxt  = 1'b0;
            end // otherwise hold every counter
        end else if (!csn_s && sclk_rise) begin
            unique case (sp_r)
                SP_INSTR: begin
                    ish_nxt = w;
                    bit_nxt = bit_r + 5'h01;
                    if (bit_r == INSTR_LAST) begin
                        sp_nxt   = SP_DATA;
                        bit_nxt  = '0;
                        bcnt_nxt = '0;
                        rd_nxt   = w.rd;
                        len_nxt  = w.length_code_bits;
                        addr_nxt = w.start_reg_address;
                        if (w.rd) begin
                            tx_nxt  = rd_byte({3'h0, w.start_reg_address});
                            drv_nxt = 1'b1;
                        end
                    end
                end
                SP_DATA: begin
                    rx_nxt  = rxb;
                    bit_nxt = bit_r + 5'h01;
                    if (bit_r == BYTE_LAST) begin
                        bit_nxt  = '0;
                        bcnt_nxt = bcnt_r + 2'h1;
                        addr_nxt = astep;
                        if (!rd_r) begin
                            spi_wr.en   = 1'b1;
                            spi_wr.addr = {3'h0, addr_r};
                            spi_wr.data = rxb;
                        end
                        if (len_r != LEN_STREAM && bcnt_r == len_r) begin
                            sp_nxt  = SP_DONE;
                            drv_nxt = 1'b0;
                        end else if (rd_r)
                            tx_nxt = rd_byte({3'h0, astep});
                    end
                end
                SP_DONE: begin
                    bit_nxt = '0; // extra clocks after the count are ignored
                end
                default: begin
                    sp_nxt = SP_INSTR;
                end
            endcase
        end else if (!csn_s && sclk_fall && sp_r == SP_DATA && rd_r) begin
            obit_nxt = lsb_first ? tx_r[0] : tx_r[7];
            tx_nxt   = lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sp_r   <= SP_INSTR;
            bit_r  <= '0;
            ish_r  <= '0;
            rx_r   <= '0;
            tx_r   <= '0;
            addr_r <= '0;
            rd_r   <= 1'b0;
            drv_r  <= 1'b0;
            obit_r <= 1'b0;
            len_r  <= '0;
            bcnt_r <= '0;
        end else begin
            sp_r   <= sp_nxt;
            bit_r  <= bit_nxt;
            ish_r  <= ish_nxt;
            rx_r   <= rx_nxt;
            tx_r   <= tx_nxt;
            addr_r <= addr_nxt;
            rd_r   <= rd_nxt;
            drv_r  <= drv_nxt;
            obit_r <= obit_nxt;
            len_r  <= len_nxt;
            bcnt_r <= bcnt_nxt;
        end
    end

    // enables follow the synchronised select, so release lags the pin by a few clocks
    assign sdio_out        = obit_r;
    assign serial_out_pin  = obit_r;
    assign sdio_oe_n       = ~(spi_mode & drv_r & ~csn_s & ~unidir);
    assign serial_out_oe_n = ~(spi_mode & drv_r & ~csn_s & unidir);

    // ------------------------------------------------------------
    // i2c engine
    // ------------------------------------------------------------
    scp_i2c_state_t is_r, is_nxt;
    logic [3:0]  icnt_r, icnt_nxt;
    logic [7:0]  ish8_r, ish8_nxt;
    logic [15:0] ptr_r, ptr_nxt;
    logic [1:0]  idx_r, idx_nxt;
    logic        rnw_r, rnw_nxt, hit_r, hit_nxt, sdrv_r, sdrv_nxt;

    always_comb begin
        logic [7:0] b;
        b        = {ish8_r[6:0], sda_s};
        is_nxt   = is_r;
        icnt_nxt = icnt_r;
        ish8_nxt = ish8_r;
        ptr_nxt  = ptr_r;
        idx_nxt  = idx_r;
        rnw_nxt  = rnw_r;
        hit_nxt  = hit_r;
        sdrv_nxt = sdrv_r;
        i2c_wr   = '0;
        if (spi_mode || i2c_stop) begin
            is_nxt   = I_IDLE; // pointer kept across stop
            sdrv_nxt = 1'b0;
        end else if (i2c_start) begin // repeated start too
            is_nxt   = I_ADDR;
            icnt_nxt = '0;
            sdrv_nxt = 1'b0;
        end else if (scl_rise) begin
            unique case (is_r)
                I_ADDR, I_RX: begin
                    ish8_nxt = b;
                    icnt_nxt = icnt_r + 4'h1;
                    if (icnt_r == BYTE_LAST[3:0]) begin
                        if (is_r == I_ADDR) begin
                            hit_nxt = (b[7:1] == i2c_slave_addr);
                            rnw_nxt = b[0];
                            idx_nxt = '0;
                        end else begin
                            idx_nxt = (idx_r == 2'h2) ? idx_r : idx_r + 2'h1;
                            if (idx_r == 2'h0)
                                ptr_nxt = {b, ptr_r[7:0]};
                            else if (idx_r == 2'h1)
                                ptr_nxt = {ptr_r[15:8], b};
                            else begin
                                i2c_wr.en   = 1'b1;
                                i2c_wr.addr = ptr_r;
                                i2c_wr.data = b;
                                ptr_nxt     = ptr_r + I2C_STEP;
                            end
                        end
                    end
                end
                I_TX: begin
                    icnt_nxt = icnt_r + 4'h1;
                end
                I_TXACK: begin
                    ptr_nxt = ptr_r + I2C_STEP;
                    is_nxt  = sda_s ? I_IDLE : I_ACK; // no-ack ends the read
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (is_r)
                I_ADDR, I_RX: begin
                    if (icnt_r == I2C_ACK_CNT) begin
                        if (is_r == I_ADDR && !hit_r)
                            is_nxt = I_IDLE;
                        else begin
                            is_nxt   = I_ACK;
                            sdrv_nxt = 1'b1; // acknowledge every data byte, and the address byte only on a match
                        end
                    end
                end
                I_ACK: begin
                    icnt_nxt = '0;
                    if (rnw_r) begin
                        b        = rd_byte(ptr_r);
                        sdrv_nxt = ~b[7];
                        ish8_nxt = {b[6:0], 1'b0};
                        is_nxt   = I_TX;
                    end else begin
                        sdrv_nxt = 1'b0;
                        is_nxt   = I_RX;
                    end
                end
                I_TX: begin
                    if (icnt_r == I2C_ACK_CNT) begin
                        sdrv_nxt = 1'b0; // let the host answer
                        is_nxt   = I_TXACK;
                    end else begin
                        sdrv_nxt = ~ish8_r[7];
                        ish8_nxt = {ish8_r[6:0], 1'b0};
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            is_r   <= I_IDLE;
            icnt_r <= '0;
            ish8_r <= '0;
            ptr_r  <= '0;
            idx_r  <= '0;
            rnw_r  <= 1'b0;
            hit_r  <= 1'b0;
            sdrv_r <= 1'b0;
        end else begin
            is_r   <= is_nxt;
            icnt_r <= icnt_nxt;
            ish8_r <= ish8_nxt;
            ptr_r  <= ptr_nxt;
            idx_r  <= idx_nxt;
            rnw_r  <= rnw_nxt;
            hit_r  <= hit_nxt;
            sdrv_r <= sdrv_nxt;
        end
    end

    // open drain: only ever pulls low
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~sdrv_r;

endmodule : scp_serial_control_port

`default_nettype wire

// *** testbench/scp_serial_control_port_props.sv ***
// concurrent checks on the serial control port pins, spi side
// assumes one clock domain and the async active-low resetn
`timescale 1ns/1ps
`default_nettype none
module scp_port_chk
    import scp_pkg::*;
(
    input wire logic               clock,
    input wire logic               resetn,
    input wire logic               sclk,
    input wire logic               csn,
    input wire logic               sdio_out,
    input wire logic               sdio_oe_n,
    input wire logic               serial_out_oe_n,
    input wire logic [ARR_N*8-1:0] active_regs,
    input wire logic               update_pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // --------------------------------------------------------
    // sequences
    // --------------------------------------------------------
    // five samples cover the two-flop csn synchroniser
    sequence s_cs_idle;
        csn[*5];
    endsequence
    sequence s_quiet;
        (!csn && !sclk)[*4];
    endsequence

    // --------------------------------------------------------
    // assertions
    // --------------------------------------------------------
    AST_CS_RELEASE: assert property (s_cs_idle |-> sdio_oe_n && serial_out_oe_n)
        else $error("data outputs driven while deselected");
    AST_ONE_PIN: assert property (!sdio_oe_n |-> serial_out_oe_n)
        else $error("both data outputs driven");
    AST_READ_ON_FALL: assert property ($changed(sdio_out) && !sdio_oe_n && $past(!sdio_oe_n)
        |-> !$past(sclk) && !$past(sclk, 2))
        else $error("read bit moved outside sclk low");
    AST_SDIO_TURN: assert property ($fell(sdio_oe_n) |-> !csn && sclk)
        else $error("sdio turned around off the instruction edge");
    AST_SDO_TURN: assert property ($fell(serial_out_oe_n) |-> !csn && sclk)
        else $error("separate output enabled off the instruction edge");
    AST_OE_HOLD: assert property (!sdio_oe_n ##1 s_quiet |-> !sdio_oe_n)
        else $error("read drive dropped without sclk or csn");
    AST_UPD_SINGLE: assert property (update_pulse |=> !update_pulse)
        else $error("update pulse longer than one cycle");
    AST_UPD_FRAME: assert property (update_pulse |-> !$past(csn, 4))
        else $error("update outside a selected frame");
    AST_ACTIVE_UPD: assert property ($changed(active_regs) |-> ##[0:1] update_pulse)
        else $error("active registers changed without update");
endmodule // scp_port_chk

bind scp_serial_control_port scp_port_chk chk_u (
    .clock           (clock),
    .resetn          (resetn),
    .sclk            (sclk),
    .csn             (csn),
    .sdio_out        (sdio_out),
    .sdio_oe_n       (sdio_oe_n),
    .serial_out_oe_n (serial_out_oe_n),
    .active_regs     (active_regs),
    .update_pulse    (update_pulse)
);
`default_nettype wire

// *** testbench/scp_spi_host.sv ***
// far-side spi master: drives sclk, csn and host data, reads back
// assumes the bench resolves the sdio and sdo wires from all enables
`timescale 1ns/1ps
`default_nettype none
module scp_spi_host (
    output var  logic sclk,
    output var  logic csn,
    output var  logic host_d,
    output var  logic host_oe,
    input  wire logic sdio_w,
    input  wire logic sdo_w
);
    logic uni;
    initial begin
        sclk = 1'b0;
        csn = 1'b1;
        host_d = 1'b0;
        host_oe = 1'b0;
        uni = 1'b0;
    end
    // csn held one sclk period so the synchroniser sees every level
    task automatic cs(input logic v);
        csn = v;
        #125;
    endtask
    // msb first; sclk stands low between frames
    task automatic shift(input int n, input logic [47:0] v, input logic drv, output logic [47:0] q);
        q = '0;
        host_oe = drv;
        for (int i = n - 1; i >= 0; i--) begin
            host_d = v[i];
            #62.5 sclk = 1'b1;
            q[i] = uni ? sdo_w : sdio_w;
            #62.5 sclk = 1'b0;
        end
        host_oe = 1'b0;
    endtask
endmodule // scp_spi_host
`default_nettype wire

// *** testbench/scp_serial_control_port_test.sv ***
// self-checking bench for the serial control port, spi side
// assumes scp_spi_host as far-side master and the bound checker
`timescale 1ns/1ps
`default_nettype none
module scp_serial_control_port_test;
    import scp_pkg::*;
    logic               clock, resetn, sclk, csn, host_d, host_oe;
    logic               spi_mode, scl_in, sda_in;
    logic [6:0]         slave_addr;
    logic               sdio_out, sdio_oe_n, serial_out_pin, serial_out_oe_n, update_pulse;
    logic [ARR_N*8-1:0] active_regs;
    logic [47:0]        r;
    int                 fails, n_checks, upd_n;
    wire                sdio_w, sdo_w;

    // undriven wire shows the inverse of the last value
    assign sdio_w = !sdio_oe_n ? sdio_out : (host_oe ? host_d : ~host_d);
    assign sdo_w  = !serial_out_oe_n ? serial_out_pin : ~serial_out_pin;

    scp_serial_control_port dut_u (.clock(clock), .resetn(resetn), .spi_mode(spi_mode),
        .i2c_slave_addr(slave_addr), .sclk(sclk), .csn(csn), .sdio_in(sdio_w), .sdio_out(sdio_out),
        .sdio_oe_n(sdio_oe_n), .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n),
        .scl_in(scl_in), .sda_in(sda_in), .sda_out(), .sda_oe_n(), .active_regs(active_regs),
        .update_pulse(update_pulse));
    scp_spi_host host_u (.sclk(sclk), .csn(csn), .host_d(host_d), .host_oe(host_oe),
        .sdio_w(sdio_w), .sdo_w(sdo_w));

    always #4 clock = ~clock;
    always @(posedge clock) if (update_pulse === 1'b1) upd_n++;

    function automatic logic [15:0] ins(logic rw, logic [1:0] len, logic [12:0] a);
        scp_instr_t i = '{rw, len, a};
        return i;
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] len, input logic [12:0] a, input int nb, input logic [47:0] d);
        host_u.cs(1'b0);
        host_u.shift(16, ins(1'b0, len, a), 1'b1, r);
        host_u.shift(8 * nb, d, 1'b1, r);
        host_u.cs(1'b1);
    endtask
    task automatic rd(input logic [1:0] len, input logic [12:0] a, input int nb);
        host_u.cs(1'b0);
        host_u.shift(16, ins(1'b1, len, a), 1'b1, r);
        host_u.shift(8 * nb, 48'h0, 1'b0, r);
        host_u.cs(1'b1);
    endtask
    task automatic results();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // --------------------------------------------------------
    // sequence
    // --------------------------------------------------------
    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        spi_mode = 1'b1;
        scl_in = 1'b1;
        sda_in = 1'b1;
        slave_addr = 7'h2a;
        fails = 0;
        n_checks = 0;
        upd_n = 0;
        repeat (3) @(posedge clock);
        #1 resetn = 1'b1;
        repeat (4) @(posedge clock);
        // odd phase keeps host edges off the clock edges
        #1.25;
        chk({sdio_oe_n, serial_out_oe_n}, 2'b11);
        host_u.cs(1'b0);
        host_u.shift(16, ins(1'b0, 2'h2, 13'h12), 1'b1, r);
        host_u.cs(1'b1);
        host_u.cs(1'b0);
        host_u.shift(8, 48'ha1, 1'b1, r);
        host_u.cs(1'b1);
        host_u.cs(1'b0);
        host_u.shift(16, 48'hb2c3, 1'b1, r);
        host_u.cs(1'b1);
        chk(active_regs, 64'h0);
        rd(2'h2, 13'h12, 3);
        chk(r, 48'ha1b2c3);
        wr(2'h0, ADDR_UPDATE[12:0], 1, 48'h01);
        chk(active_regs, 64'ha1b2c3);
        chk(upd_n, 1);
        rd(2'h0, ADDR_UPDATE[12:0], 1);
        chk(r, 48'h0);
        wr(2'h3, 13'h17, 4, 48'h11223344);
        // partial byte, then a paused frame abandoned by three clocks
        host_u.cs(1'b0);
        host_u.shift(16, ins(1'b0, 2'h0, 13'h13), 1'b1, r);
        host_u.shift(5, 48'h1f, 1'b1, r);
        host_u.cs(1'b1);
        host_u.cs(1'b0);
        host_u.shift(16, ins(1'b0, 2'h1, 13'h13), 1'b1, r);
        host_u.cs(1'b1);
        host_u.cs(1'b0);
        host_u.shift(3, 48'h0, 1'b1, r);
        host_u.cs(1'b1);
        rd(2'h1, 13'h14, 2);
        chk(r, 48'h4400);
        rd(2'h3, 13'h17, 5);
        chk(r, 48'h1122334400);
        wr(2'h0, ADDR_READ_SEL[12:0], 1, 48'h01);
        rd(2'h0, 13'h17, 1);
        chk(r, 48'h0);
        wr(2'h0, ADDR_PORT_CFG[12:0], 1, 48'h81);
        host_u.uni = 1'b1;
        rd(2'h0, 13'h10, 1);
        chk(r, 48'hc3);
        rd(2'h0, ADDR_PORT_CFG[12:0], 1);
        chk(r, 48'h81);
        results();
    end
    initial begin
        #500000;
        fails++;
        $display("[FAIL] %0t run did not finish", $time);
        results();
    end
endmodule // scp_serial_control_port_test
`default_nettype wire
